/* File: src/mta_pkg.sv */
package mta_pkg;

	localparam int NCH = 2;

	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_CFG_A  = 8'h04;
	localparam logic [7:0] OFS_CFG_B  = 8'h08;
	localparam logic [7:0] OFS_STAT   = 8'h0C;
	localparam logic [7:0] OFS_ERR    = 8'h10;
	localparam logic [7:0] OFS_RES_A  = 8'h14;
	localparam logic [7:0] OFS_RES_B  = 8'h18;
	localparam logic [7:0] OFS_GLOBAL = 8'h1C;

	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_CH_LSB  = 4;
	localparam int CMD_ARG_BIT = 8;
	localparam int CMD_SRC_LSB = 12;

	// config word fields
	localparam int CFG_CONT_BIT = 0;
	localparam int CFG_DLY_BIT  = 1;
	localparam int CFG_SRC_LSB  = 4;

	// error codes, two's complement
	localparam logic [31:0] ERR_NONE       = 32'h0000_0000;
	localparam logic [31:0] ERR_INIT_IGN   = 32'hFFFF_FF2B;
	localparam logic [31:0] ERR_TRIG_IGN   = 32'hFFFF_FF2D;
	localparam logic [31:0] ERR_SUFFIX_RNG = 32'hFFFF_FF22;

	// settling pause and measurement timing
	localparam int SETTLE_NS      = 1000;
	localparam int CLK_NS         = 8;
	localparam int SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int MEAS_CYC       = 4;
	localparam logic [7:0] CNT_W0 = 8'h00;

	// reset values
	localparam logic RST_CONT = 1'b0;
	localparam logic RST_DLY  = 1'b1;
	localparam logic PWR_CONT = 1'b1;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_INIT_IMM,
		OP_INIT_CONT,
		OP_INIT_IMM_ALL,
		OP_INIT_CONT_ALL,
		OP_TRIG_IMM,
		OP_ABORT,
		OP_SET_SRC,
		OP_SET_DLY,
		OP_SOFT_RESET,
		OP_PRESET
	} mta_op_t;

	typedef enum logic [1:0] {
		SRC_BUS,
		SRC_REAR_INPUT_ORIGIN,
		SRC_HOLD,
		SRC_IMM
	} mta_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SETTLE,
		ST_MEAS
	} mta_state_t;

	typedef struct packed {
		logic     cont;
		logic     dly;
		mta_src_t src;
	} mta_cfg_t;

	typedef struct packed {
		logic       valid;
		mta_op_t    op;
		logic [1:0] ch;
		logic       arg;
	} mta_cmd_t;

endpackage

/* File: src/mta_trigger_arming.sv */
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - soft reset turns continuous arming off
// - preset keeps rear-input channels, else continuous on
// - per-channel continuous readback: 1 continuous, 0 single
// - single arm waits, trigger measures, stores result
// - immediate origin measures at once on arm
// - arm when busy or continuous gives -213
// - global continuous command sets all channels
// - global continuous readback: 1 all continuous
// - continuous off: idle until armed, one cycle
// - continuous on: cycles repeat without idle
// - trigger cycle leaves wait, starts measurement
// - soft reset disables, preset enables sequence continuous
// - global single arm arms all, same checks
// - settling option inserts pause before measuring
// - settling off measures right at trigger
// - soft reset turns settling on; readback 1/0
// - force trigger in wait triggers, stores result
// - force trigger outside wait gives -211
// - origin selection records only, never arms
// - index 1 is A, 2 is B, others rejected
// - abort returns a waiting channel to idle, rearms if continuous
// - pending flag set while any channel busy
module mta_trigger_arming #(
	parameter logic SINGLE_CH = 1'b0
)(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// trigger and measurement front end
	input  wire logic        rear_input_origin,
	input  wire logic        bus_trig,
	input  wire logic [15:0] meas_data_a,
	input  wire logic [15:0] meas_data_b,
	// status
	output logic             pending_r,
	output logic [1:0]       meas_busy_r
);

	localparam int N = mta_pkg::NCH;

	// address phase capture
	logic        wr_pend_r;
	logic [7:0]  addr_r;
	// read taken at its address phase, mapped window only
	logic        rd_take;

	mta_pkg::mta_cfg_t   cfg_r   [N];
	mta_pkg::mta_state_t st_r    [N];
	logic [7:0]          cnt_r   [N];
	logic [15:0]         res_r   [N];
	logic [31:0]         err_r;
	mta_pkg::mta_cmd_t   cmd;
	logic [N-1:0]        hit;
	logic [N-1:0]        trig_ev;
	logic [N-1:0]        arm_ok;
	logic                ch_bad;
	logic                any_busy;
	logic [31:0]         rd_nxt;
	logic                idx_op;
	logic                arm_bad;
	logic                trig_bad;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= hsel & htrans[1] & hwrite;
			addr_r    <= haddr[7:0];
		end
	end

	assign rd_take = hready && hsel && htrans[1] && !hwrite &&
		haddr[31:8] == 24'h00_0000;

	// zero wait states, always okay
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// command decode from write to command register
	always_comb
	begin
		cmd.valid = wr_pend_r && addr_r == mta_pkg::OFS_CMD;
		cmd.op    = mta_pkg::mta_op_t'(hwdata[mta_pkg::CMD_OP_LSB +: 4]);
		cmd.ch    = hwdata[mta_pkg::CMD_CH_LSB +: 2];
		cmd.arg   = hwdata[mta_pkg::CMD_ARG_BIT];
	end

	// channel index 1 is a, 2 is b
	always_comb
	begin
		hit    = '0;
		ch_bad = 1'b0;
		if (cmd.ch == 2'd1)
			hit[0] = 1'b1;
		else if (cmd.ch == 2'd2 && !SINGLE_CH)
			hit[1] = 1'b1;
		else
			ch_bad = 1'b1;
	end

	always_comb
	begin
		any_busy = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			arm_ok[i] = st_r[i] == mta_pkg::ST_IDLE && !cfg_r[i].cont;
			any_busy  = any_busy | (st_r[i] != mta_pkg::ST_IDLE);
		end
	end

	// trigger events per channel
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			unique case (cfg_r[i].src)
				mta_pkg::SRC_IMM:
					trig_ev[i] = 1'b1;
				mta_pkg::SRC_REAR_INPUT_ORIGIN:
					trig_ev[i] = rear_input_origin;
				mta_pkg::SRC_BUS:
					trig_ev[i] = bus_trig;
				mta_pkg::SRC_HOLD:
					trig_ev[i] = 1'b0;
			endcase
			// force trigger works from any origin, hold included
			if (cmd.valid && cmd.op == mta_pkg::OP_TRIG_IMM && hit[i])
				trig_ev[i] = 1'b1;
		end
	end

	// settings, one set per channel
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < N; i++)
			begin
				cfg_r[i].cont <= mta_pkg::PWR_CONT;
				cfg_r[i].dly  <= mta_pkg::RST_DLY;
				cfg_r[i].src  <= mta_pkg::SRC_IMM;
			end
		end
		else if (cmd.valid)
		begin
			for (int i = 0; i < N; i++)
			begin
				unique case (cmd.op)
					mta_pkg::OP_INIT_CONT:
						if (hit[i])
							cfg_r[i].cont <= cmd.arg;
					mta_pkg::OP_INIT_CONT_ALL:
						cfg_r[i].cont <= cmd.arg;
					// origin has its own field, clear of the index
					mta_pkg::OP_SET_SRC:
						if (hit[i])
							cfg_r[i].src <= mta_pkg::mta_src_t'(
								hwdata[mta_pkg::CMD_SRC_LSB +: 2]);
					mta_pkg::OP_SET_DLY:
						if (hit[i])
							cfg_r[i].dly <= cmd.arg;
					mta_pkg::OP_SOFT_RESET:
					begin
						cfg_r[i].cont <= mta_pkg::RST_CONT;
						cfg_r[i].dly  <= mta_pkg::RST_DLY;
						cfg_r[i].src  <= mta_pkg::SRC_IMM;
					end
					mta_pkg::OP_PRESET:
						if (cfg_r[i].src != mta_pkg::SRC_REAR_INPUT_ORIGIN)
							cfg_r[i].cont <= 1'b1;
					default:
						;
				endcase
			end
		end
	end

	// per-channel sequencer
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < N; i++)
			begin
				st_r[i]  <= mta_pkg::ST_IDLE;
				cnt_r[i] <= mta_pkg::CNT_W0;
				res_r[i] <= 16'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				unique case (st_r[i])
					// continuous arming leaves idle on its own
					mta_pkg::ST_IDLE:
						if (cfg_r[i].cont)
							st_r[i] <= mta_pkg::ST_WAIT;
						else if (cmd.valid && arm_ok[i] &&
							((cmd.op == mta_pkg::OP_INIT_IMM && hit[i]) ||
							cmd.op == mta_pkg::OP_INIT_IMM_ALL))
							st_r[i] <= mta_pkg::ST_WAIT;
					mta_pkg::ST_WAIT:
						if (cmd.valid && cmd.op == mta_pkg::OP_ABORT && hit[i])
							st_r[i] <= mta_pkg::ST_IDLE;
						else if (trig_ev[i])
						begin
							cnt_r[i] <= mta_pkg::CNT_W0;
							if (cfg_r[i].dly)
								st_r[i] <= mta_pkg::ST_SETTLE;
							else
								st_r[i] <= mta_pkg::ST_MEAS;
						end
					mta_pkg::ST_SETTLE:
						if (cnt_r[i] == 8'(mta_pkg::SETTLE_CYC - 1))
						begin
							cnt_r[i] <= mta_pkg::CNT_W0;
							st_r[i]  <= mta_pkg::ST_MEAS;
						end
						else
							cnt_r[i] <= cnt_r[i] + 8'h01;
					mta_pkg::ST_MEAS:
						if (cnt_r[i] == 8'(mta_pkg::MEAS_CYC - 1))
						begin
							cnt_r[i] <= mta_pkg::CNT_W0;
							res_r[i] <= (i == 0) ? meas_data_a : meas_data_b;
							if (cfg_r[i].cont)
								st_r[i] <= mta_pkg::ST_WAIT;
							else
								st_r[i] <= mta_pkg::ST_IDLE;
						end
						else
							cnt_r[i] <= cnt_r[i] + 8'h01;
				endcase
			end
		end
	end

	// command checks, one flag for each error code
	always_comb
	begin
		idx_op   = cmd.op == mta_pkg::OP_INIT_IMM ||
			cmd.op == mta_pkg::OP_INIT_CONT ||
			cmd.op == mta_pkg::OP_TRIG_IMM ||
			cmd.op == mta_pkg::OP_ABORT ||
			cmd.op == mta_pkg::OP_SET_SRC ||
			cmd.op == mta_pkg::OP_SET_DLY;
		arm_bad  = 1'b0;
		if (cmd.op == mta_pkg::OP_INIT_IMM)
			arm_bad = !(hit[0] ? arm_ok[0] : arm_ok[N-1]);
		else if (cmd.op == mta_pkg::OP_INIT_IMM_ALL)
			arm_bad = arm_ok != '1;
		trig_bad = cmd.op == mta_pkg::OP_TRIG_IMM &&
			(hit[0] ? st_r[0] : st_r[N-1]) != mta_pkg::ST_WAIT;
	end

	// last error code; cleared as its read is taken,
	// so an error raised in that same cycle still stands
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			err_r <= mta_pkg::ERR_NONE;
		else
		begin
			if (rd_take && haddr[7:0] == mta_pkg::OFS_ERR)
				err_r <= mta_pkg::ERR_NONE;
			if (cmd.valid && idx_op && ch_bad)
				err_r <= mta_pkg::ERR_SUFFIX_RNG;
			else if (cmd.valid && arm_bad)
				err_r <= mta_pkg::ERR_INIT_IGN;
			else if (cmd.valid && trig_bad)
				err_r <= mta_pkg::ERR_TRIG_IGN;
		end
	end

	// pending flag, high while any channel is away from idle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pending_r <= 1'b0;
		else
			pending_r <= any_busy;
	end

	// busy per channel while settling or measuring
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			meas_busy_r <= 2'b00;
		else
			for (int i = 0; i < N; i++)
				meas_busy_r[i] <= st_r[i] == mta_pkg::ST_SETTLE ||
					st_r[i] == mta_pkg::ST_MEAS;
	end

	// read mux, decoded from the address phase
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		unique case (haddr[7:0])
			mta_pkg::OFS_CFG_A:
			begin
				rd_nxt[mta_pkg::CFG_CONT_BIT] = cfg_r[0].cont;
				rd_nxt[mta_pkg::CFG_DLY_BIT]  = cfg_r[0].dly;
				rd_nxt[mta_pkg::CFG_SRC_LSB +: 2] = cfg_r[0].src;
			end
			mta_pkg::OFS_CFG_B:
			begin
				rd_nxt[mta_pkg::CFG_CONT_BIT] = cfg_r[N-1].cont;
				rd_nxt[mta_pkg::CFG_DLY_BIT]  = cfg_r[N-1].dly;
				rd_nxt[mta_pkg::CFG_SRC_LSB +: 2] = cfg_r[N-1].src;
			end
			mta_pkg::OFS_STAT:
			begin
				rd_nxt[1:0] = st_r[0];
				rd_nxt[3:2] = st_r[N-1];
				rd_nxt[4]   = pending_r;
			end
			mta_pkg::OFS_ERR:
				rd_nxt = err_r;
			mta_pkg::OFS_RES_A:
				rd_nxt[15:0] = res_r[0];
			mta_pkg::OFS_RES_B:
				rd_nxt[15:0] = res_r[N-1];
			mta_pkg::OFS_GLOBAL:
				rd_nxt[0] = cfg_r[0].cont & cfg_r[N-1].cont;
			default:
				rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data captured at the address phase edge and held,
	// so it stands through the whole data phase
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= rd_nxt;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= 32'h0000_0000;
	end

endmodule

/* File: tb/mta_trigger_arming_chk.sv */
`timescale 1ns/1ps
module mta_trigger_arming_chk (
	// clock, reset
	input wire logic        clock,
	input wire logic        rst,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// status
	input wire logic        pending_r,
	input wire logic [1:0]  meas_busy_r
);
	localparam int BMAX = 140;
	int cnt_a;
	int cnt_b;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// busy run lengths
	always_ff @(posedge clock or posedge rst)
		if (rst)
			cnt_a <= 0;
		else
			cnt_a <= meas_busy_r[0] ? cnt_a + 1 : 0;
	always_ff @(posedge clock or posedge rst)
		if (rst)
			cnt_b <= 0;
		else
			cnt_b <= meas_busy_r[1] ? cnt_b + 1 : 0;
	a_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_busy_pend: assert property (|meas_busy_r |-> pending_r)
		else $error("pending low while busy");
	a_meas_len_a: assert property ($rose(meas_busy_r[0])
		|-> meas_busy_r[0][*4]) else $error("short measure a");
	a_meas_len_b: assert property ($rose(meas_busy_r[1])
		|-> meas_busy_r[1][*4]) else $error("short measure b");
	a_busy_max_a: assert property (cnt_a <= BMAX)
		else $error("busy too long a");
	a_busy_max_b: assert property (cnt_b <= BMAX)
		else $error("busy too long b");
	a_unmapped_zero: assert property (hsel && htrans[1] && hready
		&& !hwrite && haddr >= 32'h0000_0020 |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	cover property ($rose(meas_busy_r[0]));
	cover property ($fell(pending_r));
	cover property (hsel && htrans[1] && hwrite);
endmodule
bind mta_trigger_arming mta_trigger_arming_chk u_chk (
	.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.pending_r(pending_r), .meas_busy_r(meas_busy_r)
);

/* File: tb/mta_host.sv */
`timescale 1ns/1ps
module mta_host (
	// clock
	input wire logic        clock,
	// bus
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	output logic            hsel,
	output logic [31:0]     haddr,
	output logic [1:0]      htrans,
	output logic            hwrite,
	output logic [2:0]      hsize,
	output logic [31:0]     hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'hA5A5_A5A5;
	end
	// one single word transfer
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
		// released data lines must not look valid
		hwdata <= ~d;
	endtask
endmodule

/* File: tb/mta_trigger_arming_tb_top.sv */
`timescale 1ns/1ps
module mta_trigger_arming_tb_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic        rear_in = 1'b0;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        pending_r;
	logic [1:0]  meas_busy_r;
	logic [15:0] da;
	logic [15:0] db;
	logic [31:0] seed = 32'h3683_6865;
	logic [31:0] q;
	int          fails = 0;
	int          checks = 0;
	int          m_cont[2];
	int          m_dly[2];
	int          m_src[2];
	always #4 clock = ~clock;
	mta_trigger_arming u_dut (
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .rear_input_origin(rear_in),
		.bus_trig(1'b0), .meas_data_a(da), .meas_data_b(db),
		.pending_r(pending_r), .meas_busy_r(meas_busy_r)
	);
	mta_host u_host (
		.clock(clock), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] cfg(int i);
		return (m_src[i] << 4) | (m_dly[i] << 1) | m_cont[i];
	endfunction
	task automatic srcset(input logic [1:0] ch, s);
		u_host.xfer(1'b1, 32'h0, {18'h0, s, 6'h0, ch, 4'h7}, q);
	endtask
	task automatic rdm(input logic [31:0] a, m, e);
		u_host.xfer(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [3:0] op, logic [1:0] ch, logic arg);
		u_host.xfer(1'b1, 32'h0, {23'h0, arg, 2'h0, ch, op}, q);
	endtask
	task automatic rdc(input logic [31:0] a, e);
		u_host.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#40000;
		fails++;
		finish_test();
	end
	initial
	begin
		m_cont = '{1, 1};
		m_dly = '{1, 1};
		m_src = '{3, 3};
		@(posedge clock);
		q = rnd();
		da <= q[15:0];
		db <= q[31:16];
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdc(mta_pkg::OFS_CFG_A, cfg(0));
		rdc(mta_pkg::OFS_CFG_B, cfg(1));
		rdc(mta_pkg::OFS_GLOBAL, 32'h1);
		$display("test reset done");
		cmd(4'h9, 2'h1, 1'b0);
		m_cont = '{0, 0};
		rdc(mta_pkg::OFS_CFG_A, cfg(0));
		rdc(mta_pkg::OFS_GLOBAL, 32'h0);
		repeat (300) @(negedge clock);
		chk({31'h0, pending_r}, 32'h0);
		cmd(4'h8, 2'h1, 1'b0);
		m_dly[0] = 0;
		rdc(mta_pkg::OFS_CFG_A, cfg(0));
		rdc(mta_pkg::OFS_CFG_B, cfg(1));
		$display("test soft reset done");
		cmd(4'h1, 2'h1, 1'b0);
		cmd(4'h1, 2'h1, 1'b0);
		rdc(mta_pkg::OFS_ERR, mta_pkg::ERR_INIT_IGN);
		repeat (30) @(posedge clock);
		rdc(mta_pkg::OFS_RES_A, {16'h0, da});
		rdc(mta_pkg::OFS_STAT, 32'h0);
		cmd(4'h5, 2'h1, 1'b0);
		rdc(mta_pkg::OFS_ERR, mta_pkg::ERR_TRIG_IGN);
		cmd(4'h1, 2'h3, 1'b0);
		rdc(mta_pkg::OFS_ERR, mta_pkg::ERR_SUFFIX_RNG);
		rdc(32'h20, 32'h0);
		$display("test single arm done");
		q = rnd();
		da <= q[15:0];
		db <= q[31:16];
		srcset(2'h1, 2'h2);
		m_src[0] = 2;
		rdc(mta_pkg::OFS_CFG_A, cfg(0));
		rdc(mta_pkg::OFS_STAT, 32'h0);
		cmd(4'h1, 2'h1, 1'b0);
		rdc(mta_pkg::OFS_STAT, 32'h11);
		cmd(4'h5, 2'h1, 1'b0);
		repeat (10) @(posedge clock);
		rdc(mta_pkg::OFS_RES_A, {16'h0, da});
		rdc(mta_pkg::OFS_ERR, mta_pkg::ERR_NONE);
		cmd(4'h1, 2'h1, 1'b0);
		cmd(4'h6, 2'h1, 1'b0);
		rdc(mta_pkg::OFS_STAT, 32'h0);
		$display("test force and abort done");
		srcset(2'h1, 2'h3);
		m_src[0] = 3;
		cmd(4'h1, 2'h1, 1'b0);
		rdc(mta_pkg::OFS_STAT, 32'h13);
		cmd(4'h1, 2'h2, 1'b0);
		rdc(mta_pkg::OFS_STAT, 32'h18);
		repeat (140) @(posedge clock);
		rdc(mta_pkg::OFS_RES_B, {16'h0, db});
		rdc(mta_pkg::OFS_STAT, 32'h0);
		$display("test settling done");
		srcset(2'h2, 2'h1);
		m_src[1] = 1;
		cmd(4'ha, 2'h0, 1'b0);
		m_cont[0] = 1;
		rdc(mta_pkg::OFS_CFG_A, cfg(0));
		rdc(mta_pkg::OFS_CFG_B, cfg(1));
		q = rnd();
		db <= q[31:16];
		cmd(4'h1, 2'h2, 1'b0);
		rdm(mta_pkg::OFS_STAT, 32'h0000_000C, 32'h0000_0004);
		rear_in <= 1'b1;
		@(posedge clock);
		rear_in <= 1'b0;
		repeat (140) @(posedge clock);
		rdc(mta_pkg::OFS_RES_B, {16'h0, db});
		rdm(mta_pkg::OFS_STAT, 32'h0000_000C, 32'h0000_0000);
		$display("test origin and preset done");
		cmd(4'h4, 2'h0, 1'b1);
		m_cont = '{1, 1};
		rdc(mta_pkg::OFS_GLOBAL, 32'h1);
		rdc(mta_pkg::OFS_CFG_B, cfg(1));
		cmd(4'h3, 2'h0, 1'b0);
		rdc(mta_pkg::OFS_ERR, mta_pkg::ERR_INIT_IGN);
		repeat (20) @(negedge clock);
		chk({31'h0, pending_r}, 32'h1);
		cmd(4'h6, 2'h2, 1'b0);
		rdm(mta_pkg::OFS_STAT, 32'h0000_000C, 32'h0000_0004);
		$display("test continuous done");
		finish_test();
	end
endmodule
